// [design/power_arbiter_pkg.sv]
package power_arbiter_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] RESET_CONTROL_IDX = 16'h4006;
  localparam logic [15:0] SYSTEM_STATUS_IDX = 16'h400D;
  localparam logic [15:0] INT_STATUS1_IDX   = 16'h4011;
  localparam logic [15:0] INT_MASK1_IDX     = 16'h4019;

  // ==========================================================
  // field positions
  localparam int BATT_SW_EN_BIT     = 12;
  localparam int WALL_STRONG_BIT    = 13;
  localparam int BATT_SRC_BIT       = 10;
  localparam int WALL_PRES_BIT      = 9;
  localparam int USB_PRES_BIT       = 8;
  localparam int SRC_CHG_FLAG_BIT   = 14;
  localparam int SRC_CHG_MASK_BIT   = 14;

  // ==========================================================
  // reset values
  localparam logic BATT_SW_EN_RST   = 1'h0;
  localparam logic WALL_STRONG_RST  = 1'h0;
  localparam logic STATUS_BIT_RST   = 1'h0;
  localparam logic SRC_CHG_FLAG_RST = 1'h0;
  localparam logic SRC_CHG_MASK_RST = 1'h1;

  // ==========================================================
  // bus constants
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SRC_BATT = 3'b001,
    SRC_USB  = 3'b010,
    SRC_WALL = 3'b100
  } source_t;

  typedef enum logic [3:0] {
    PS_OFF   = 4'b0001,
    PS_ON    = 4'b0010,
    PS_SLEEP = 4'b0100,
    PS_OTHER = 4'b1000
  } power_state_t;

  // comparator results and battery sense, straight from the pins
  typedef struct packed {
    logic wall_above_5v5;
    logic wall_above_4v3;
    logic wall_above_3v4;
    logic wall_above_batt;
    logic usb_above_5v5;
    logic usb_above_4v3;
    logic usb_above_batt;
    logic usb_above_wall;
    logic battery_connected;
    logic load_exceeds_source;
  } comparator_t;

  typedef struct packed {
    logic    wall_present;
    logic    usb_present;
    source_t source;
  } selection_t;

  typedef struct packed {
    logic battery_switch_gate_n;
    logic battery_switch_gate_oe_n;
    logic wall_switch_gate_n;
    logic wall_gate_strong_drive;
  } gate_drive_t;

endpackage

// [design/source_select.sv]
`timescale 1ns/10ps

module source_select
  import power_arbiter_pkg::*;
(
  input  power_arbiter_pkg::comparator_t cmp,
  output power_arbiter_pkg::selection_t  sel
);
  import power_arbiter_pkg::*;

  logic wall_normal;
  logic wall_low_ok;
  logic usb_highest;
  logic usb_normal;
  logic usb_low_ok;

  // wall inside its 4.3 V to 5.5 V window and above the battery
  assign wall_normal = cmp.wall_above_4v3 & ~cmp.wall_above_5v5
                       & cmp.wall_above_batt;
  // wall below 4.3 V still usable when usb is below 4.3 V too
  assign wall_low_ok = ~cmp.wall_above_4v3 & ~cmp.usb_above_4v3
                       & cmp.wall_above_batt;
  assign usb_highest = cmp.usb_above_batt & cmp.usb_above_wall;
  assign usb_normal  = cmp.usb_above_4v3 & ~cmp.usb_above_5v5
                       & ~cmp.wall_above_4v3 & usb_highest;
  assign usb_low_ok  = ~cmp.usb_above_4v3 & ~cmp.wall_above_3v4
                       & usb_highest;

  always_comb begin
    sel.wall_present = wall_normal | wall_low_ok;
    sel.usb_present  = usb_normal | usb_low_ok;
    // fixed preference: wall, then usb, then battery
    if (sel.wall_present) begin
      sel.source = SRC_WALL;
    end else if (sel.usb_present) begin
      sel.source = SRC_USB;
    end else begin
      sel.source = SRC_BATT;
    end
  end

endmodule

// [design/power_source_arbiter.sv]
`timescale 1ns/10ps

// How it works
// - preference order is wall, then usb, then battery
// - wall chosen inside 4.3-5.5 V window when above battery
// - wall chosen below 4.3 V if usb below 4.3 V, wall above battery
// - usb never chosen while wall is inside its normal window
// - battery chosen when it is above both wall and usb
// - new wall or usb reselects on the fly, no stop
// - battery may supplement wall or usb when load demands
// - status bits 9 wall and 8 usb presence, reset 0
// - status bit 10 set whenever battery delivers current, reset 0
// - wall or usb status change raises change flag, battery not
// - enable bit 12 gates active-low battery switch gate output
// - enable bit 12 cleared at reset and on entering OFF
// - battery switch held open throughout charging
// - bit 13 picks weak (0, reset) or strong wall gate drive
// - charging from wall or usb only in ON or SLEEP
// - usb selection window below 4.3 V wall, low-voltage fallback below 3.4 V wall
// - change flag bit 14 at 0x4011, rising edge set, write 1 clears
// - mask bit 14 at 0x4019 resets to 1, 0 unmasks
module power_source_arbiter
  import power_arbiter_pkg::*;
(
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           clk_en,
  // ahb-lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  // comparators and battery sense pins
  input  wire power_arbiter_pkg::comparator_t cmp_pins,
  // same-clock system inputs
  input  wire power_arbiter_pkg::power_state_t power_state,
  input  wire logic                           charger_active,
  // outputs to the power path
  output power_arbiter_pkg::gate_drive_t      gate_drive,
  output power_arbiter_pkg::source_t          selected_source,
  output logic                                charge_permit,
  output logic                                source_change_irq
);
  import power_arbiter_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic access_ok(input logic [31:0] a,
                                     input logic [2:0]  s);
    access_ok = (s == HSIZE_WORD) && (a[1:0] == 2'h0)
                && (a[31:18] == 14'h0);
  endfunction

  function automatic logic [15:0] word_index(input logic [31:0] a);
    word_index = a[17:2];
  endfunction

  // ==========================================================
  // comparator synchroniser
  comparator_t cmp_meta_q;
  comparator_t cmp_sync_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_meta_q <= '0;
      cmp_sync_q <= '0;
    end else if (clk_en) begin
      cmp_meta_q <= cmp_pins;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // ==========================================================
  // source selection
  selection_t sel_d;

  source_select u_select (
    .cmp (cmp_sync_q),
    .sel (sel_d)
  );

  logic        batt_sourcing_d;
  logic        wall_present_q;
  logic        usb_present_q;
  logic        batt_sourcing_q;
  source_t     source_q;
  logic        supplement_d;

  // battery tops up the selected external source under heavy load
  assign supplement_d = (sel_d.source != SRC_BATT)
                        & cmp_sync_q.battery_connected
                        & cmp_sync_q.load_exceeds_source;
  assign batt_sourcing_d = ((sel_d.source == SRC_BATT)
                            & cmp_sync_q.battery_connected)
                           | supplement_d;

  // every result registered on the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_q        <= SRC_BATT;
      wall_present_q  <= STATUS_BIT_RST;
      usb_present_q   <= STATUS_BIT_RST;
      batt_sourcing_q <= STATUS_BIT_RST;
    end else if (clk_en) begin
      source_q        <= sel_d.source;
      wall_present_q  <= sel_d.wall_present;
      usb_present_q   <= sel_d.usb_present;
      batt_sourcing_q <= batt_sourcing_d;
    end
  end

  assign selected_source = source_q;

  // ==========================================================
  // ahb-lite slave: one wait state per transfer
  logic        dphase_q;
  logic        waited_q;
  logic        wr_q;
  logic        ok_q;
  logic [15:0] idx_q;
  logic [31:0] rdata_q;
  logic        accept;
  logic        wr_now;

  assign accept    = clk_en & hready & hsel & htrans[1];
  assign hreadyout = clk_en & ~(dphase_q & ~waited_q);
  assign hresp     = HRESP_OKAY;
  assign hrdata    = rdata_q;
  // write lands in the waited cycle, hwdata is stable then
  assign wr_now    = clk_en & dphase_q & ~waited_q & wr_q & ok_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_q <= 1'h0;
      waited_q <= 1'h0;
      wr_q     <= 1'h0;
      ok_q     <= 1'h0;
      idx_q    <= 16'h0;
    end else if (clk_en) begin
      if (accept) begin
        dphase_q <= 1'h1;
        waited_q <= 1'h0;
        wr_q     <= hwrite;
        ok_q     <= access_ok(haddr, hsize);
        idx_q    <= word_index(haddr);
      end else if (dphase_q && !waited_q) begin
        waited_q <= 1'h1;
      end else if (hready) begin
        dphase_q <= 1'h0;
        waited_q <= 1'h0;
      end
    end
  end

  // ==========================================================
  // control register
  logic         batt_sw_en_q;
  logic         wall_strong_q;
  power_state_t prev_state_q;
  logic         off_entry;

  assign off_entry = (power_state == PS_OFF) && (prev_state_q != PS_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_state_q <= PS_OFF;
    end else if (clk_en) begin
      prev_state_q <= power_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      batt_sw_en_q  <= BATT_SW_EN_RST;
      wall_strong_q <= WALL_STRONG_RST;
    end else if (clk_en) begin
      if (wr_now && idx_q == RESET_CONTROL_IDX) begin
        batt_sw_en_q  <= hwdata[BATT_SW_EN_BIT];
        wall_strong_q <= hwdata[WALL_STRONG_BIT];
      end
      // entering OFF overrides a same-cycle write
      if (off_entry) begin
        batt_sw_en_q <= 1'h0;
      end
    end
  end

  // ==========================================================
  // source change flag and mask
  logic change_cond;
  logic change_prev_q;
  logic flag_q;
  logic mask_q;

  // battery availability is left out of the change condition
  assign change_cond = (sel_d.wall_present != wall_present_q)
                       | (sel_d.usb_present != usb_present_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      change_prev_q <= 1'h0;
    end else if (clk_en) begin
      change_prev_q <= change_cond;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= SRC_CHG_FLAG_RST;
    end else if (clk_en) begin
      // set after clear so a same-cycle event wins
      if (wr_now && idx_q == INT_STATUS1_IDX
          && hwdata[SRC_CHG_FLAG_BIT]) begin
        flag_q <= 1'h0;
      end
      if (change_cond && !change_prev_q) begin
        flag_q <= 1'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= SRC_CHG_MASK_RST;
    end else if (clk_en && wr_now && idx_q == INT_MASK1_IDX) begin
      mask_q <= hwdata[SRC_CHG_MASK_BIT];
    end
  end

  assign source_change_irq = flag_q & ~mask_q;

  // ==========================================================
  // read data, loaded in the waited cycle
  logic [15:0] rd_word;

  always_comb begin
    rd_word = 16'h0;
    case (idx_q)
      RESET_CONTROL_IDX: begin
        rd_word[BATT_SW_EN_BIT]  = batt_sw_en_q;
        rd_word[WALL_STRONG_BIT] = wall_strong_q;
      end
      SYSTEM_STATUS_IDX: begin
        rd_word[BATT_SRC_BIT]  = batt_sourcing_q;
        rd_word[WALL_PRES_BIT] = wall_present_q;
        rd_word[USB_PRES_BIT]  = usb_present_q;
      end
      INT_STATUS1_IDX: begin
        rd_word[SRC_CHG_FLAG_BIT] = flag_q;
      end
      INT_MASK1_IDX: begin
        rd_word[SRC_CHG_MASK_BIT] = mask_q;
      end
      default: begin
        rd_word = 16'h0;
      end
    endcase
    if (!ok_q) begin
      rd_word = 16'h0;
    end
  end

  // status register has no write path at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0;
    end else if (clk_en && dphase_q && !waited_q) begin
      rdata_q <= wr_q ? 32'h0 : {16'h0, rd_word};
    end
  end

  // ==========================================================
  // switch gates and charge permission
  logic        charge_ok_d;
  gate_drive_t gate_d;
  gate_drive_t gate_q;
  logic        charge_permit_q;

  assign charge_ok_d = (sel_d.source != SRC_BATT)
                       & cmp_sync_q.battery_connected
                       & ((power_state == PS_ON)
                          | (power_state == PS_SLEEP));

  always_comb begin
    gate_d = '0;
    gate_d.wall_switch_gate_n     = (sel_d.source != SRC_WALL);
    gate_d.wall_gate_strong_drive = wall_strong_q;
    // released pin while the function is disabled
    gate_d.battery_switch_gate_oe_n = ~batt_sw_en_q;
    gate_d.battery_switch_gate_n    = ~(batt_sw_en_q & batt_sourcing_d
                                        & ~charger_active);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q          <= '{battery_switch_gate_n:    1'h1,
                           battery_switch_gate_oe_n: 1'h1,
                           wall_switch_gate_n:       1'h1,
                           wall_gate_strong_drive:   1'h0};
      charge_permit_q <= 1'h0;
    end else if (clk_en) begin
      gate_q          <= gate_d;
      charge_permit_q <= charge_ok_d;
    end
  end

  assign gate_drive    = gate_q;
  assign charge_permit = charge_permit_q;

endmodule

// [verif/power_source_arbiter_sva.sv]
`timescale 1ns/10ps

module power_source_arbiter_sva
  import power_arbiter_pkg::*;
(
  input wire logic                            hclk,
  input wire logic                            hresetn,
  input wire logic                            hsel,
  input wire logic [1:0]                      htrans,
  input wire logic                            hready,
  input wire logic                            hreadyout,
  input wire power_arbiter_pkg::comparator_t  cmp_pins,
  input wire power_arbiter_pkg::power_state_t power_state,
  input wire logic                            charger_active,
  input wire power_arbiter_pkg::gate_drive_t  gate_drive,
  input wire power_arbiter_pkg::source_t      selected_source,
  input wire logic                            charge_permit
);
  import power_arbiter_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // checks
  a_wait_state: assert property (
    hready && hsel && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("bus transfer did not take one wait state");
  a_gate_off: assert property (
    gate_drive.battery_switch_gate_oe_n |-> gate_drive.battery_switch_gate_n)
    else $error("battery gate on while pin disabled");
  a_charge_open: assert property (
    charger_active |=> gate_drive.battery_switch_gate_n)
    else $error("battery switch closed while charging");
  a_charge_state: assert property (
    power_state == PS_OFF || power_state == PS_OTHER |=> !charge_permit)
    else $error("charging permitted outside on or sleep");
  a_one_source: assert property (
    $onehot(selected_source))
    else $error("selected source not one-hot");
  a_source_settled: assert property (
    $stable(cmp_pins) [*5] |-> $stable(selected_source))
    else $error("source changed with steady comparators");
  a_off_clears: assert property (
    $changed(power_state) && power_state == PS_OFF
    |-> ##[1:2] gate_drive.battery_switch_gate_oe_n)
    else $error("battery switch enable kept after off entry");
  a_wall_gate: assert property (
    selected_source == SRC_WALL |-> !gate_drive.wall_switch_gate_n)
    else $error("wall switch off while wall selected");
endmodule

bind power_source_arbiter power_source_arbiter_sva chk_u (
  .hclk            (hclk),
  .hresetn         (hresetn),
  .hsel            (hsel),
  .htrans          (htrans),
  .hready          (hready),
  .hreadyout       (hreadyout),
  .cmp_pins        (cmp_pins),
  .power_state     (power_state),
  .charger_active  (charger_active),
  .gate_drive      (gate_drive),
  .selected_source (selected_source),
  .charge_permit   (charge_permit)
);

// [verif/supply_model.sv]
`timescale 1ns/10ps

// ==========================================================
// comparator outputs for a few supply situations
module supply_model
  import power_arbiter_pkg::*;
(
  input  wire logic [2:0]                    scene,
  input  wire logic                          load_high,
  output power_arbiter_pkg::comparator_t     cmp_pins
);
  import power_arbiter_pkg::*;
  logic [7:0] src_bits;

  always_comb begin
    case (scene)
      3'h1:    src_bits = 8'h70;
      3'h2:    src_bits = 8'h77;
      3'h3:    src_bits = 8'h07;
      3'h4:    src_bits = 8'h32;
      3'h5:    src_bits = 8'h03;
      default: src_bits = 8'h00;
    endcase
  end

  assign cmp_pins = {src_bits, 1'b1, load_high};
endmodule

// [verif/power_source_arbiter_tb.sv]
`timescale 1ns/10ps

module power_source_arbiter_tb;
  import power_arbiter_pkg::*;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = HTRANS_IDLE;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hready;
  logic         hresp;
  logic [2:0]   scene = 3'h0;
  logic         load_high = 1'b0;
  comparator_t  cmp_pins;
  power_state_t power_state = PS_ON;
  logic         charger_active = 1'b0;
  gate_drive_t  gate_drive;
  source_t      selected_source;
  logic         charge_permit;
  logic         irq;
  int           err_count = 0;
  int           check_count = 0;
  int           cyc = 0;
  logic [31:0]  rd;
  source_t      exp_src [6] = '{SRC_WALL, SRC_WALL, SRC_USB, SRC_WALL,
                                SRC_USB, SRC_BATT};
  logic [31:0]  exp_sts [6] = '{32'h200, 32'h200, 32'h100, 32'h200,
                                32'h100, 32'h400};

  always #10 hclk = ~hclk;

  supply_model pins_u (
    .scene     (scene),
    .load_high (load_high),
    .cmp_pins  (cmp_pins)
  );

  power_source_arbiter dut_u (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .clk_en            (1'b1),
    .hsel              (1'b1),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (HSIZE_WORD),
    .hwdata            (hwdata),
    .hready            (hready),
    .hrdata            (hrdata),
    .hreadyout         (hready),
    .hresp             (hresp),
    .cmp_pins          (cmp_pins),
    .power_state       (power_state),
    .charger_active    (charger_active),
    .gate_drive        (gate_drive),
    .selected_source   (selected_source),
    .charge_permit     (charge_permit),
    .source_change_irq (irq)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [31:0] wd);
    @(posedge hclk);
    haddr  <= {14'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic set_pins(input logic [2:0] s, input logic ld);
    @(posedge hclk);
    scene     <= s;
    load_high <= ld;
    repeat (5) @(posedge hclk);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    rchk(RESET_CONTROL_IDX, 32'h0);
    rchk(INT_MASK1_IDX, 32'h4000);
    rchk(INT_STATUS1_IDX, 32'h0);
    rchk(SYSTEM_STATUS_IDX, 32'h400);
    rchk(16'h4000, 32'h0);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    for (int i = 0; i < 6; i++) begin
      set_pins((i == 5) ? 3'h0 : 3'(i + 1), 1'b0);
      chk({29'h0, selected_source}, {29'h0, exp_src[i]});
      xfer(1'b0, SYSTEM_STATUS_IDX, 32'h0);
      chk(rd & 32'h700, exp_sts[i]);
    end
    set_pins(3'h1, 1'b0);
    xfer(1'b1, INT_STATUS1_IDX, 32'h4000);
    rchk(INT_STATUS1_IDX, 32'h0);
    xfer(1'b1, INT_MASK1_IDX, 32'h0);
    set_pins(3'h1, 1'b1);
    rchk(SYSTEM_STATUS_IDX, 32'h600);
    chk({31'h0, irq}, 32'h0);
    set_pins(3'h3, 1'b0);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, INT_MASK1_IDX, 32'h4000);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, INT_STATUS1_IDX, 32'h4000);
    rchk(INT_STATUS1_IDX, 32'h0);
    set_pins(3'h0, 1'b0);
    xfer(1'b1, RESET_CONTROL_IDX, 32'h3000);
    rchk(RESET_CONTROL_IDX, 32'h3000);
    chk({28'h0, gate_drive}, 32'h3);
    @(posedge hclk);
    charger_active <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({28'h0, gate_drive}, 32'hB);
    charger_active <= 1'b0;
    power_state    <= PS_OFF;
    repeat (3) @(posedge hclk);
    rchk(RESET_CONTROL_IDX, 32'h2000);
    chk({28'h0, gate_drive}, 32'hF);
    xfer(1'b1, SYSTEM_STATUS_IDX, 32'hFFFF);
    rchk(SYSTEM_STATUS_IDX, 32'h400);
    set_pins(3'h1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      power_state <= power_state_t'(4'h1 << i);
      repeat (3) @(posedge hclk);
      chk({31'h0, charge_permit}, {31'h0, i == 1 || i == 2});
    end
    finish_test();
  end
endmodule
